// *** hw/eac_pkg.sv ***
// Constants for the on-chip data store access controller.
// Assumes an 8-bit I/O port with 6-bit register addresses on the core clock.
package eac_pkg;
	// Register addresses on the I/O port
	localparam logic [5:0] OFS_CONTROL = 6'h1f;
	localparam logic [5:0] OFS_DATA = 6'h20;
	localparam logic [5:0] OFS_ADDR_LOW = 6'h21;
	localparam logic [5:0] OFS_ADDR_HIGH = 6'h22;
	// Control register field positions
	localparam int BIT_READ = 0;
	localparam int BIT_PROG = 1;
	localparam int BIT_ARM = 2;
	localparam int BIT_RDY_IE = 3;
	localparam int BIT_MODE_LO = 4;
	localparam int BIT_MODE_HI = 5;
	// Store geometry
	localparam int ADDR_W = 12;
	localparam int DEPTH = 4096;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// Programming mode encodings
	localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
	localparam logic [1:0] MODE_ERASE = 2'h1;
	localparam logic [1:0] MODE_WRITE = 2'h2;
	localparam logic [1:0] MODE_RSVD = 2'h3;
	// Reset values
	localparam logic [1:0] MODE_RESET = 2'h0;
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int ARM_CYCLES = 4;
	localparam int READ_STALL = 4;
	localparam int PROG_STALL = 2;
	localparam int WRITE_TIME_NS = 4500000;
	localparam int ERASE_TIME_NS = 8500000;
	localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 19;
	// Programming sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ERASE,
		ST_WRITE
	} eac_state_e;
endpackage : eac_pkg

// *** hw/eac_eeprom_ctrl.sv ***
// Data store access controller: address, data and control registers,
// a 4K-byte byte-wide store, self-timed erase/write and core stall.
// Assumes I/O port strobes are one-cycle and synchronous to core_clk.
//
// What this block does
// - 12-bit linear byte address, high nibble plus low byte.
// - Address is undefined after reset; software must load it first.
// - Data register supplies write byte and receives read byte.
// - Mode field: 0 erase+write, 1 erase, 2 write, 3 reserved.
// - Mode field writes ignored while program strobe is set.
// - Reset clears mode field unless programming is in progress.
// - Ready interrupt is a level while strobe is zero and enabled.
// - Program strobe only starts work within four cycles of arming.
// - Arm bit clears itself four cycles after software sets it.
// - Program strobe clears when the timed interval ends.
// - Setting the program strobe without the read strobe stalls the core two cycles.
// - No programming starts while flash self-programming is busy.
// - Programming in progress completes across a reset.
// - High address bits 7:4 and control bits 7:6 read zero.
// - Control layout mode 5:4, enable 3, arm 2, strobe 1, read 0.
// - Read strobe loads data at once and stalls core four cycles.
// - Busy store refuses reads and address changes.
// - Write takes 4.5 ms and erase 8.5 ms.
`timescale 1ns/1ps
module eac_eeprom_ctrl #(
	parameter int WRITE_CYC = eac_pkg::WRITE_CYCLES,
	parameter int ERASE_CYC = eac_pkg::ERASE_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// I/O register port
	input wire logic [5:0] ioAddr,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [7:0] ioWdata,
	output logic [7:0] ioRdata,
	// Core side
	input wire logic globalIntEnable,
	input wire logic selfProgramBusy,
	output logic readyIrq,
	output logic cpuStall,
	output logic storeBusy
);
	import eac_pkg::*;

	localparam logic [TIMER_W-1:0] WRITE_LOAD = TIMER_W'(WRITE_CYC - 1);
	localparam logic [TIMER_W-1:0] ERASE_LOAD = TIMER_W'(ERASE_CYC - 1);

	// Store array
	logic [7:0] storeMem [DEPTH];

	// Register state
	logic [ADDR_W-1:0] storeAddress;
	logic [7:0] storeData;
	logic [1:0] progMode;
	logic readyIntEnable;
	logic armBit;
	logic [2:0] armCnt;
	logic progStrobe;
	logic [2:0] stallCnt;
	logic [ADDR_W-1:0] next_storeAddress;
	logic [7:0] next_storeData;
	logic [1:0] next_progMode;
	logic next_readyIntEnable;
	logic next_armBit;
	logic [2:0] next_armCnt;
	logic [2:0] next_stallCnt;

	// Sequencer state
	eac_state_e state;
	eac_state_e next_state;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	logic [ADDR_W-1:0] opAddr;
	logic [ADDR_W-1:0] next_opAddr;
	logic [7:0] opData;
	logic [7:0] next_opData;
	logic [1:0] opMode;
	logic [1:0] next_opMode;

	// Decoded strobes
	logic wrCtrl;
	logic wrData;
	logic wrAddrLow;
	logic wrAddrHigh;
	logic busy;
	logic startProg;
	logic startRead;
	logic memWe;
	logic [7:0] memWdata;

	// Address match helper for port writes
	function automatic logic hitWrite(input logic [5:0] a, input logic [5:0] ofs,
		input logic we);
		hitWrite = we && (a == ofs);
	endfunction : hitWrite

	// Port write decode
	always_comb begin
		wrCtrl = hitWrite(ioAddr, OFS_CONTROL, ioWrite);
		wrData = hitWrite(ioAddr, OFS_DATA, ioWrite);
		wrAddrLow = hitWrite(ioAddr, OFS_ADDR_LOW, ioWrite);
		wrAddrHigh = hitWrite(ioAddr, OFS_ADDR_HIGH, ioWrite);
	end

	// Busy means an operation runs; the strobe bit mirrors it
	assign busy = (state != ST_IDLE);
	assign progStrobe = busy;
	assign storeBusy = busy;

	// Accepted program and read requests
	always_comb begin
		startProg = wrCtrl && ioWdata[BIT_PROG] && armBit
			&& !busy && !selfProgramBusy
			&& (progMode != MODE_RSVD);
		startRead = wrCtrl && ioWdata[BIT_READ] && !busy;
	end

	// Next register values
	always_comb begin
		next_storeAddress = storeAddress;
		next_storeData = storeData;
		next_progMode = progMode;
		next_readyIntEnable = readyIntEnable;
		next_armBit = armBit;
		next_armCnt = armCnt;
		next_stallCnt = (stallCnt != 3'h0) ? stallCnt - 3'h1 : 3'h0;
		// Address frozen while busy
		if (wrAddrLow && !busy) begin
			next_storeAddress[7:0] = ioWdata;
		end else if (wrAddrHigh && !busy) begin
			next_storeAddress[ADDR_W-1:8] = ioWdata[3:0];
		end
		if (wrData) begin
			next_storeData = ioWdata;
		end
		// Arm window countdown
		if (armCnt != 3'h0) begin
			next_armCnt = armCnt - 3'h1;
			if (armCnt == 3'h1) begin
				next_armBit = 1'b0;
			end
		end
		if (wrCtrl) begin
			next_readyIntEnable = ioWdata[BIT_RDY_IE];
			if (!busy && !startProg) begin
				next_progMode = ioWdata[BIT_MODE_HI:BIT_MODE_LO];
			end else if (startProg) begin
				next_progMode = ioWdata[BIT_MODE_HI:BIT_MODE_LO];
			end
			if (ioWdata[BIT_ARM] && !ioWdata[BIT_PROG]) begin
				next_armBit = 1'b1;
				next_armCnt = 3'(ARM_CYCLES);
			end else if (startProg) begin
				next_armBit = 1'b0;
				next_armCnt = 3'h0;
			end
		end
		// Read lands in the data register the same cycle
		if (startRead) begin
			next_storeData = storeMem[storeAddress];
			next_stallCnt = 3'(READ_STALL);
		end else if (startProg) begin
			next_stallCnt = 3'(PROG_STALL);
		end
	end

	// Register update; mode survives reset while busy
	always_ff @(posedge core_clk) begin
		storeAddress <= next_storeAddress;
		storeData <= next_storeData;
		if (!rst_b) begin
			readyIntEnable <= 1'b0;
			armBit <= 1'b0;
			armCnt <= 3'h0;
			stallCnt <= 3'h0;
			if (!busy) begin
				progMode <= MODE_RESET;
			end
		end else begin
			readyIntEnable <= next_readyIntEnable;
			armBit <= next_armBit;
			armCnt <= next_armCnt;
			stallCnt <= next_stallCnt;
			progMode <= next_progMode;
		end
	end

	// Sequencer next state
	always_comb begin
		next_state = state;
		next_timer = timer;
		next_opAddr = opAddr;
		next_opData = opData;
		next_opMode = opMode;
		memWe = 1'b0;
		memWdata = storeMem[opAddr];
		case (state)
			ST_IDLE: begin
				next_timer = '0;
				if (startProg) begin
					next_opAddr = storeAddress;
					next_opData = (wrData) ? ioWdata : storeData;
					next_opMode = ioWdata[BIT_MODE_HI:BIT_MODE_LO];
					if (ioWdata[BIT_MODE_HI:BIT_MODE_LO] == MODE_WRITE) begin
						next_state = ST_WRITE;
						next_timer = WRITE_LOAD;
					end else begin
						next_state = ST_ERASE;
						next_timer = ERASE_LOAD;
					end
				end
			end
			ST_ERASE: begin
				if (timer != '0) begin
					next_timer = timer - TIMER_W'(1);
				end else begin
					memWe = 1'b1;
					memWdata = ERASED_BYTE;
					if (opMode == MODE_ERASE_WRITE) begin
						next_state = ST_WRITE;
						next_timer = WRITE_LOAD;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_WRITE: begin
				if (timer != '0) begin
					next_timer = timer - TIMER_W'(1);
				end else begin
					// Programming only clears bits
					memWe = 1'b1;
					memWdata = storeMem[opAddr] & opData;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Sequencer registers; reset only acts when idle
	always_ff @(posedge core_clk) begin
		if (!rst_b && !busy) begin
			state <= ST_IDLE;
			timer <= '0;
		end else begin
			state <= next_state;
			timer <= next_timer;
		end
		opAddr <= next_opAddr;
		opData <= next_opData;
		opMode <= next_opMode;
	end

	// Store array write port
	always_ff @(posedge core_clk) begin
		if (memWe) begin
			storeMem[opAddr] <= memWdata;
		end
	end

	// Port read data
	always_comb begin
		ioRdata = 8'h00;
		if (ioRead && ioAddr == OFS_CONTROL) begin
			ioRdata[BIT_MODE_HI:BIT_MODE_LO] = progMode;
			ioRdata[BIT_RDY_IE] = readyIntEnable;
			ioRdata[BIT_ARM] = armBit;
			ioRdata[BIT_PROG] = progStrobe;
			ioRdata[BIT_READ] = 1'b0;
		end else if (ioRead && ioAddr == OFS_DATA) begin
			ioRdata = storeData;
		end else if (ioRead && ioAddr == OFS_ADDR_LOW) begin
			ioRdata = storeAddress[7:0];
		end else if (ioRead && ioAddr == OFS_ADDR_HIGH) begin
			ioRdata = {4'h0, storeAddress[ADDR_W-1:8]};
		end
	end

	// Core outputs
	assign readyIrq = readyIntEnable && globalIntEnable && !progStrobe;
	assign cpuStall = (stallCnt != 3'h0);
endmodule : eac_eeprom_ctrl

// *** verification/eac_ctrl_checker.sv ***
// Port checker for the data store access controller.
// Assumes binding onto eac_eeprom_ctrl, sharing its timing parameters.
`timescale 1ns/1ps
module eac_ctrl_checker #(
	parameter int WRITE_CYC = 20,
	parameter int ERASE_CYC = 30
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// I/O register port
	input wire logic [5:0] ioAddr,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [7:0] ioWdata,
	input wire logic [7:0] ioRdata,
	// Core side
	input wire logic globalIntEnable,
	input wire logic selfProgramBusy,
	input wire logic readyIrq,
	input wire logic cpuStall,
	input wire logic storeBusy
);
	import eac_pkg::*;
	logic ctlWr, armWr, strWr;
	logic [2:0] armAge, next_armAge;
	logic [19:0] busyLen, next_busyLen;
	// Control writes that arm or strobe
	assign ctlWr = ioWrite && ioAddr == OFS_CONTROL;
	assign armWr = ctlWr && ioWdata[BIT_ARM] && !ioWdata[BIT_PROG];
	assign strWr = ctlWr && ioWdata[BIT_PROG] && !storeBusy;
	// Age of the arm window and length of the busy run
	always_comb begin
		// Age 1..4 is inside the window, 5 means expired
		next_armAge = armWr ? 3'h1 : (armAge == 3'h5 ? armAge : armAge + 3'h1);
		if (!rst_b) begin
			next_armAge = 3'h5;
		end
		next_busyLen = storeBusy ? busyLen + 20'h1 : 20'h0;
	end
	always_ff @(posedge core_clk) begin
		armAge <= next_armAge;
		busyLen <= next_busyLen;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_irq_level: assert property (readyIrq |-> globalIntEnable && !storeBusy)
		else $error("ready irq while busy or masked");
	a_prog_stall: assert property ($rose(storeBusy) |-> cpuStall ##1 cpuStall ##1 !cpuStall)
		else $error("program stall not two cycles");
	a_read_stall: assert property (ctlWr && ioWdata[BIT_READ] && !ioWdata[BIT_PROG]
		&& !storeBusy && !cpuStall |=> cpuStall [*4] ##1 !cpuStall)
		else $error("read stall not four cycles");
	a_arm_start: assert property (strWr && armAge != 3'h5 && !selfProgramBusy
		&& ioWdata[5:4] != MODE_RSVD |=> storeBusy) else $error("armed strobe did not start");
	a_arm_expire: assert property (strWr && armAge == 3'h5 |=> !storeBusy)
		else $error("strobe after arm window started");
	a_spm_block: assert property (strWr && selfProgramBusy |=> !storeBusy)
		else $error("started while flash busy");
	a_rsvd_idle: assert property (strWr && ioWdata[5:4] == MODE_RSVD |=> !storeBusy)
		else $error("reserved mode started");
	a_busy_len: assert property ($fell(storeBusy) |-> busyLen == WRITE_CYC
		|| busyLen == ERASE_CYC || busyLen == WRITE_CYC + ERASE_CYC)
		else $error("busy length wrong");
	a_high_zero: assert property (ioRead && ioAddr == OFS_ADDR_HIGH |-> ioRdata[7:4] == 4'h0)
		else $error("address high top bits not zero");
	a_ctl_bits: assert property (ioRead && ioAddr == OFS_CONTROL |-> ioRdata[7:6] == 2'h0
		&& ioRdata[BIT_PROG] == storeBusy) else $error("control read bits wrong");
	// Main scenarios
	cover property ($fell(storeBusy));
	cover property (strWr && armAge == 3'h4);
	cover property (readyIrq);
endmodule : eac_ctrl_checker
bind eac_eeprom_ctrl eac_ctrl_checker #(.WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC)) chk_u (
	.core_clk(core_clk), .rst_b(rst_b), .ioAddr(ioAddr), .ioWrite(ioWrite),
	.ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata), .globalIntEnable(globalIntEnable),
	.selfProgramBusy(selfProgramBusy), .readyIrq(readyIrq), .cpuStall(cpuStall),
	.storeBusy(storeBusy));

// *** verification/eac_eeprom_ctrl_test.sv ***
// Self-checking bench for the data store access controller.
// Assumes shortened erase and write times and a 50 MHz core clock.
`timescale 1ns/1ps
module eac_eeprom_ctrl_test;
	import eac_pkg::*;
	logic core_clk = 0, rst_b = 0, ioWrite = 0, ioRead = 0, intEn = 0, spBusy = 0;
	logic [5:0] ioAddr = 6'h00;
	logic [7:0] ioWdata = 8'h00, ioRdata, d;
	logic readyIrq, cpuStall, storeBusy;
	logic [11:0] adr;
	logic [7:0] mem [int];
	int fail_count = 0, checks = 0;
	eac_eeprom_ctrl #(.WRITE_CYC(20), .ERASE_CYC(30)) dut_u (.core_clk(core_clk),
		.rst_b(rst_b), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioWdata(ioWdata),
		.ioRdata(ioRdata), .globalIntEnable(intEn), .selfProgramBusy(spBusy),
		.readyIrq(readyIrq), .cpuStall(cpuStall), .storeBusy(storeBusy));
	initial forever #10 core_clk = ~core_clk;
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [5:0] a, logic [7:0] v);
		@(negedge core_clk);
		ioAddr = a;
		ioWdata = v;
		ioWrite = 1;
	endtask : wr
	task automatic gap(int n);
		@(negedge core_clk);
		ioWrite = 0;
		repeat (n) @(negedge core_clk);
	endtask : gap
	task automatic rd(logic [5:0] a, logic [7:0] e);
		@(negedge core_clk);
		ioWrite = 0;
		ioAddr = a;
		ioRead = 1;
		#2 chk("ioRdata", e, ioRdata);
		// Hold the read across one rising edge so the checker sees it
		@(negedge core_clk);
		ioRead = 0;
	endtask : rd
	task automatic rst();
		rst_b = 0;
		repeat (10) @(negedge core_clk);
		rst_b = 1;
	endtask : rst
	function automatic logic [7:0] nxt(logic [7:0] o, logic [7:0] v, logic [1:0] m);
		case (m)
			MODE_ERASE_WRITE: return v;
			MODE_ERASE: return ERASED_BYTE;
			MODE_WRITE: return o & v;
			default: return o;
		endcase
	endfunction : nxt
	// Load address and data, arm, then strobe n idle edges later
	task automatic start(logic [11:0] a, logic [7:0] v, logic [1:0] m, int n);
		wr(OFS_ADDR_HIGH, {4'hf, a[11:8]});
		wr(OFS_ADDR_LOW, a[7:0]);
		wr(OFS_DATA, v);
		wr(OFS_CONTROL, {2'h0, m, 4'hc});
		if (n > 0) gap(n - 1);
		wr(OFS_CONTROL, {2'h0, m, 4'he});
		gap(0);
	endtask : start
	// Wait for idle, then read the byte back
	task automatic fin(logic [11:0] a, logic [7:0] v, logic [1:0] m, logic ok);
		for (int i = 0; i < 200 && storeBusy !== 1'b0; i++) @(negedge core_clk);
		chk("storeBusy", 8'h00, {7'h0, storeBusy});
		if (ok) mem[a] = nxt(mem[a], v, m);
		wr(OFS_CONTROL, 8'h09);
		gap(0);
		rd(OFS_DATA, mem[a]);
	endtask : fin
	task automatic prog(logic [11:0] a, logic [7:0] v, logic [1:0] m, int n);
		logic ok;
		ok = n < 4 && m != MODE_RSVD && !spBusy;
		start(a, v, m, n);
		chk("storeBusy", {7'h0, ok}, {7'h0, storeBusy});
		fin(a, v, m, ok);
	endtask : prog
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		final_report();
	end
	initial begin
		void'($urandom(23));
		rst();
		wr(OFS_ADDR_HIGH, 8'hff);
		wr(OFS_CONTROL, 8'hc8);
		gap(0);
		rd(OFS_ADDR_HIGH, 8'h0f);
		rd(OFS_CONTROL, 8'h08);
		intEn = 1;
		#2 chk("readyIrq", 8'h01, {7'h0, readyIrq});
		for (int k = 0; k < 4; k++) begin
			adr = 12'($urandom);
			d = 8'($urandom);
			prog(adr, d, MODE_ERASE, 0);
			prog(adr, d, MODE_WRITE, 2);
			prog(adr, 8'($urandom), MODE_WRITE, 1);
			prog(adr, 8'($urandom), MODE_ERASE_WRITE, k + 2);
			prog(adr, d, MODE_RSVD, 0);
		end
		spBusy = 1;
		prog(adr, 8'h00, MODE_WRITE, 0);
		spBusy = 0;
		// Writes while busy: mode, address and read strobe refused
		start(12'h5a5, 8'h3c, MODE_ERASE_WRITE, 0);
		wr(OFS_ADDR_LOW, 8'h00);
		wr(OFS_CONTROL, 8'h19);
		gap(0);
		rd(OFS_CONTROL, 8'h0a);
		fin(12'h5a5, 8'h3c, MODE_ERASE_WRITE, 1'b1);
		rd(OFS_ADDR_LOW, 8'ha5);
		intEn = 0;
		#2 chk("readyIrq", 8'h00, {7'h0, readyIrq});
		// Reset in mid-erase keeps mode and completes
		start(12'h5a5, 8'h00, MODE_ERASE, 0);
		rst();
		rd(OFS_CONTROL, 8'h12);
		fin(12'h5a5, 8'h00, MODE_ERASE, 1'b1);
		wr(OFS_CONTROL, 8'h28);
		gap(0);
		rst();
		intEn = 1;
		rd(OFS_CONTROL, 8'h00);
		chk("readyIrq", 8'h00, {7'h0, readyIrq});
		final_report();
	end
endmodule : eac_eeprom_ctrl_test
